// ### rtl/capture_pkg.sv
package capture_pkg;
  // Width of the multi-bit latch and of the pad data path
  localparam int unsigned DATA_W     = 4;
  // Bit of the pad data that feeds the single-bit elements
  localparam int unsigned SINGLE_BIT = 0;
  // Power-up values
  localparam logic        CLEAR_VAL  = 1'h0;
  localparam logic        PRESET_VAL = 1'h1;
  localparam logic [DATA_W-1:0] BUS_CLEAR_VAL = 4'h0;
endpackage : capture_pkg

// ### rtl/input_capture_flop_latch.sv
`timescale 1ns/1ps
module input_capture_flop_latch
  import capture_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [DATA_W-1:0] padData,
  input  wire logic              captureClk,
  input  wire logic              captureEnable,
  input  wire logic              globalInit,
  input  wire logic              initInvert,
  output logic                   riseFlopQ,
  output logic                   fallFlopQ,
  output logic                   highLatchQ,
  output logic                   lowLatchQ,
  output logic                   presetHighQ,
  output logic                   presetLowQ,
  output logic [DATA_W-1:0]      busLatchQ
);
  sample_if sif ();

  pin_sampler u_sampler (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .padData       (padData),
    .captureClk    (captureClk),
    .captureEnable (captureEnable),
    .globalInit    (globalInit),
    .initInvert    (initInvert),
    .sif           (sif)
  );

  // One pin serves as flop clock and latch gate, so both outputs of one element exist
  function automatic logic nextBit(input logic init, input logic initVal, input logic load,
                                   input logic dIn, input logic qOld);
    if (init) begin
      nextBit = initVal;
    end else if (load) begin
      nextBit = dIn;
    end else begin
      nextBit = qOld;
    end
  endfunction : nextBit

  logic dBit;
  assign dBit = sif.dataS[SINGLE_BIT];

  // Flops, init first so it wins over any edge
  always_ff @(posedge clk_sys) begin
    riseFlopQ <= nextBit(sif.initS, CLEAR_VAL, sif.enS & sif.rise, dBit, riseFlopQ);
    fallFlopQ <= nextBit(sif.initS, CLEAR_VAL, sif.enS & sif.fall, dBit, fallFlopQ);
  end

  // Latches load in the cycle the gate is last seen open, matching the flop edge
  always_ff @(posedge clk_sys) begin
    highLatchQ  <= nextBit(sif.initS, CLEAR_VAL, sif.gateS, dBit, highLatchQ);
    lowLatchQ   <= nextBit(sif.initS, CLEAR_VAL, ~sif.gateS, dBit, lowLatchQ);
    presetHighQ <= nextBit(sif.initS, PRESET_VAL, sif.gateS, dBit, presetHighQ);
    presetLowQ  <= nextBit(sif.initS, PRESET_VAL, ~sif.gateS, dBit, presetLowQ);
  end

  genvar i;
  generate
    for (i = 0; i < DATA_W; i++) begin : gBus
      always_ff @(posedge clk_sys) begin
        busLatchQ[i] <= nextBit(sif.initS, CLEAR_VAL, sif.gateS, sif.dataS[i], busLatchQ[i]);
      end
    end
  endgenerate

  // Edges are seen two to three clk_sys cycles late; pins must be slower than clk_sys/2

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  rise_capture_a: assert property (
    sif.enS && sif.rise && !sif.initS |=> riseFlopQ == $past(dBit))
    else $error("rising flop missed data");
  enable_hold_a: assert property (
    !sif.enS && !sif.initS |=> $stable(riseFlopQ) && $stable(fallFlopQ))
    else $error("flop changed while disabled");
  fall_capture_a: assert property (
    sif.enS && sif.fall && !sif.initS |=> fallFlopQ == $past(dBit))
    else $error("falling flop missed data");
  init_clear_a: assert property (
    sif.initS |=> !riseFlopQ && !fallFlopQ && !highLatchQ && !lowLatchQ && busLatchQ == 4'h0)
    else $error("init did not clear");
  init_hold_a: assert property (
    sif.initS [*3] |=> presetHighQ && presetLowQ && !riseFlopQ)
    else $error("init overridden");
  high_follow_a: assert property (
    sif.gateS && !sif.initS |=> highLatchQ == $past(dBit))
    else $error("high latch not transparent");
  high_hold_a: assert property (
    !sif.gateS && !sif.initS |=> $stable(highLatchQ) && $stable(busLatchQ))
    else $error("high latch not holding");
  low_follow_a: assert property (
    !sif.gateS && !sif.initS |=> lowLatchQ == $past(dBit) && presetLowQ == $past(dBit))
    else $error("low latch not transparent");
  low_hold_a: assert property (
    sif.gateS && !sif.initS |=> $stable(lowLatchQ))
    else $error("low latch not holding");
  preset_set_a: assert property (
    sif.initS |=> presetHighQ && presetLowQ)
    else $error("preset latch not set");
  bus_follow_a: assert property (
    sif.gateS && !sif.initS |=> busLatchQ == $past(sif.dataS))
    else $error("bus latch not transparent");
  master_pair_a: assert property (
    sif.fall && sif.enS && !sif.initS |=> fallFlopQ == highLatchQ)
    else $error("master latch and flop differ");

  rise_seen_c: cover property (sif.enS && sif.rise && !sif.initS);
  fall_seen_c: cover property (sif.enS && sif.fall && !sif.initS);
  hold_seen_c: cover property (!sif.enS && sif.rise && !sif.initS);
  init_seen_c: cover property (sif.initS && !rst);
endmodule : input_capture_flop_latch

// ### rtl/pin_sampler.sv
`timescale 1ns/1ps
module pin_sampler
  import capture_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [DATA_W-1:0] padData,
  input  wire logic              captureClk,
  input  wire logic              captureEnable,
  input  wire logic              globalInit,
  input  wire logic              initInvert,
  sample_if.src                  sif
);
  logic [DATA_W-1:0] dataMeta;
  logic [DATA_W-1:0] dataSync;
  logic [DATA_W-1:0] dataDly;
  logic [2:0]        clkMeta;
  logic [2:0]        clkSync;
  logic              clkDly;

  // First stage of each synchroniser feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dataMeta <= BUS_CLEAR_VAL;
      dataSync <= BUS_CLEAR_VAL;
      clkMeta  <= 3'h0;
      clkSync  <= 3'h0;
    end else begin
      dataMeta <= padData;
      dataSync <= dataMeta;
      clkMeta  <= {captureClk, captureEnable, globalInit ^ initInvert};
      clkSync  <= clkMeta;
    end
  end

  // Third stage on clock and data so edge and data line up
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dataDly <= BUS_CLEAR_VAL;
      clkDly  <= CLEAR_VAL;
    end else begin
      dataDly <= dataSync;
      clkDly  <= clkSync[2];
    end
  end

  assign sif.dataS = dataDly;
  assign sif.gateS = clkDly;
  assign sif.rise  = clkSync[2] & ~clkDly;
  assign sif.fall  = ~clkSync[2] & clkDly;
  assign sif.enS   = clkSync[1];
  // Polarity of the init pin is chosen ahead of the sampler
  assign sif.initS = clkSync[0] | rst;
endmodule : pin_sampler

// ### rtl/sample_if.sv
`timescale 1ns/1ps
interface sample_if;
  import capture_pkg::*;
  logic [DATA_W-1:0] dataS;
  logic              gateS;
  logic              rise;
  logic              fall;
  logic              enS;
  logic              initS;
  modport src (output dataS, gateS, rise, fall, enS, initS);
  modport dst (input  dataS, gateS, rise, fall, enS, initS);
endinterface : sample_if

// ### verif/input_capture_flop_latch_test.sv
`timescale 1ns/1ps
module input_capture_flop_latch_test;
  import capture_pkg::*;
  logic              clk_sys, rst, captureEnable, globalInit, initInvert, captureClk;
  logic [DATA_W-1:0] padData, busLatchQ;
  logic              riseFlopQ, fallFlopQ, highLatchQ, lowLatchQ, presetHighQ, presetLowQ;
  int                failCount, nTests;
  initial clk_sys = 1'h0;
  always #20 clk_sys = ~clk_sys;
  pad_model u_pad (.clk_sys(clk_sys), .padData(padData), .captureClk(captureClk));
  input_capture_flop_latch u_dut (.clk_sys(clk_sys), .rst(rst), .padData(padData),
    .captureClk(captureClk), .captureEnable(captureEnable), .globalInit(globalInit),
    .initInvert(initInvert), .riseFlopQ(riseFlopQ), .fallFlopQ(fallFlopQ),
    .highLatchQ(highLatchQ), .lowLatchQ(lowLatchQ), .presetHighQ(presetHighQ),
    .presetLowQ(presetLowQ), .busLatchQ(busLatchQ));
  task automatic chk(input string name, input logic [DATA_W-1:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic check_init;
    chk("riseFlopQ", DATA_W'(riseFlopQ), 4'h0);
    chk("fallFlopQ", DATA_W'(fallFlopQ), 4'h0);
    chk("highLatchQ", DATA_W'(highLatchQ), 4'h0);
    chk("lowLatchQ", DATA_W'(lowLatchQ), 4'h0);
    chk("presetHighQ", DATA_W'(presetHighQ), 4'h1);
    chk("presetLowQ", DATA_W'(presetLowQ), 4'h1);
    chk("busLatchQ", busLatchQ, 4'h0);
  endtask : check_init
  task automatic edge_path;
    u_pad.drive(4'h5, 1'h0);
    chk("lowLatchQ", DATA_W'(lowLatchQ), 4'h1);
    u_pad.drive(4'h5, 1'h1);
    chk("riseFlopQ", DATA_W'(riseFlopQ), 4'h1);
    u_pad.drive(4'h6, 1'h1);
    chk("highLatchQ", DATA_W'(highLatchQ), 4'h0);
    chk("busLatchQ", busLatchQ, 4'h6);
    chk("lowLatchQ", DATA_W'(lowLatchQ), 4'h1);
    u_pad.drive(4'h9, 1'h1);
    u_pad.drive(4'h9, 1'h0);
    chk("highLatchQ", DATA_W'(highLatchQ), 4'h1);
    chk("fallFlopQ", DATA_W'(fallFlopQ), 4'h1);
    u_pad.drive(4'h2, 1'h0);
    chk("highLatchQ", DATA_W'(highLatchQ), 4'h1);
    chk("presetHighQ", DATA_W'(presetHighQ), 4'h1);
    chk("busLatchQ", busLatchQ, 4'h9);
    chk("presetLowQ", DATA_W'(presetLowQ), 4'h0);
  endtask : edge_path
  task automatic enable_hold;
    @(posedge clk_sys);
    captureEnable <= 1'h0;
    u_pad.drive(4'h0, 1'h0);
    u_pad.drive(4'h0, 1'h1);
    u_pad.drive(4'h0, 1'h0);
    chk("riseFlopQ", DATA_W'(riseFlopQ), 4'h1);
    chk("fallFlopQ", DATA_W'(fallFlopQ), 4'h1);
    @(posedge clk_sys);
    captureEnable <= 1'h1;
  endtask : enable_hold
  task automatic init_pin;
    u_pad.drive(4'hf, 1'h1);
    @(posedge clk_sys);
    globalInit <= 1'h1;
    u_pad.drive(4'hf, 1'h0);
    check_init;
    // Inverted polarity: a low pin now means init
    @(posedge clk_sys);
    globalInit <= 1'h0;
    initInvert <= 1'h1;
    u_pad.drive(4'hf, 1'h1);
    check_init;
    @(posedge clk_sys);
    initInvert <= 1'h0;
    u_pad.drive(4'hf, 1'h0);
    chk("lowLatchQ", DATA_W'(lowLatchQ), 4'h1);
  endtask : init_pin
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    failCount++;
    give_verdict;
  end
  initial begin
    rst = 1'h1;
    captureEnable = 1'h1;
    globalInit = 1'h0;
    initInvert = 1'h0;
    failCount = 0;
    nTests = 0;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    check_init;
    @(posedge clk_sys);
    rst <= 1'h0;
    edge_path;
    enable_hold;
    init_pin;
    give_verdict;
  end
endmodule : input_capture_flop_latch_test

// ### verif/pad_model.sv
`timescale 1ns/1ps
module pad_model
  import capture_pkg::*;
(
  input  wire logic         clk_sys,
  output logic [DATA_W-1:0] padData,
  output logic              captureClk
);
  // Each level stands at least 9 clocks, well past the sampler's 2-period minimum
  localparam int HOLD = 8;
  initial begin
    padData    = 4'h0;
    captureClk = 1'h0;
  end
  // Change data and clock in separate calls so data is stable around the edge
  task automatic drive(input logic [DATA_W-1:0] d, input logic c);
    @(posedge clk_sys);
    padData    <= d;
    captureClk <= c;
    repeat (HOLD) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : drive
endmodule : pad_model
